// ### dram_sr_pkg.sv
// constants and types for the dram self-refresh and calibration sequencer
`default_nettype none
package dram_sr_pkg;

	// clk_sys period, used to turn nanosecond terms into cycles
	localparam int unsigned CLK_PERIOD_PS = 100000;

	// counter and field widths, and the number of class timers
	localparam int unsigned WAIT_W  = 11;
	localparam int unsigned CKE_W   = 5;
	localparam int unsigned PL_W    = 3;
	localparam int unsigned NUM_CLS = 3;

	// calibration windows, in device clocks
	localparam int unsigned INIT_CAL_NCK  = 1024;
	localparam int unsigned FULL_CAL_NCK  = 512;
	localparam int unsigned SHORT_CAL_NCK = 128;

	// clock-enable, clock-valid and reset/self-refresh exit figures
	localparam int unsigned CKE_PW_NCK    = 3;
	localparam int unsigned CKE_PW_NS     = 5;
	localparam int unsigned CKESR_ADD_NCK = 1;
	localparam int unsigned CK_VALID_NCK  = 5;
	localparam int unsigned CK_VALID_NS   = 10;
	localparam int unsigned XPR_NCK       = 5;
	localparam int unsigned EXIT_ADD_NS   = 10;

	// nanoseconds to whole cycles, rounded up, never below one
	function automatic int unsigned ns_to_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	function automatic int unsigned max2(input int unsigned a, input int unsigned b);
		return (a > b) ? a : b;
	endfunction : max2

	localparam int unsigned CKE_PW_CYC   = max2(CKE_PW_NCK, ns_to_cyc(CKE_PW_NS));
	localparam int unsigned CKESR_CYC    = CKE_PW_CYC + CKESR_ADD_NCK;
	localparam int unsigned CK_VALID_CYC = max2(CK_VALID_NCK, ns_to_cyc(CK_VALID_NS));

	// class timer index
	localparam int unsigned CLS_PLAIN = 0;
	localparam int unsigned CLS_FAST  = 1;
	localparam int unsigned CLS_DLL   = 2;

	// requests from the user side
	typedef enum logic [2:0] {
		REQ_ZQ_LONG  = 3'h0,
		REQ_ZQ_SHORT = 3'h1,
		REQ_MRS_FAST = 3'h2,
		REQ_PLAIN    = 3'h3,
		REQ_DLL      = 3'h4,
		REQ_SR_ENTER = 3'h5,
		REQ_SR_EXIT  = 3'h6
	} req_t;

	// command driven toward the dram
	typedef enum logic [2:0] {
		CMD_DES      = 3'h0,
		CMD_ZQ_LONG  = 3'h1,
		CMD_ZQ_SHORT = 3'h2,
		CMD_MRS      = 3'h3,
		CMD_PLAIN    = 3'h4,
		CMD_DLL      = 3'h5,
		CMD_SR_ENTER = 3'h6
	} cmd_t;

	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_PRE_CLK  = 4'h1,
		ST_XPR      = 4'h2,
		ST_INIT_CAL = 4'h3,
		ST_IDLE     = 4'h4,
		ST_BUSY     = 4'h5,
		ST_SRE_HOLD = 4'h6,
		ST_SELF_REF = 4'h7,
		ST_SRX_CLK  = 4'h8
	} state_t;

endpackage : dram_sr_pkg
`default_nettype wire

// ### class_timer.sv
// down-counting wait timer releasing one command class
`default_nettype none
module class_timer #(
	parameter int unsigned W = 11
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output var  logic         done
);

	if (W < 2) begin : g_chk
		$error("class_timer: W too small");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} tmr_t;

	tmr_t t_reg;
	tmr_t t_next;

	// done rises load_val edges after the load edge; load_val of zero acts as one
	always_comb begin
		t_next = t_reg;
		if (load) begin
			t_next.cnt  = (load_val == '0) ? '0 : W'(load_val - 1'b1);
			t_next.done = 1'b0;
		end else if (!t_reg.done) begin
			if (t_reg.cnt == '0) begin
				t_next.done = 1'b1;
			end else begin
				t_next.cnt = W'(t_reg.cnt - 1'b1);
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			t_reg <= '{cnt: '0, done: 1'b1};
		end else begin
			t_reg <= t_next;
		end
	end

	assign done = t_reg.done;

endmodule : class_timer
`default_nettype wire

// ### dram_sr_ctrl.sv
// host-side sequencer for dram reset exit, calibration and self-refresh timing
`default_nettype none
module dram_sr_ctrl #(
	parameter int unsigned RFC_NS      = 350,
	parameter int unsigned RFC4_NS     = 160,
	parameter int unsigned DLL_LOCK_CK = 768
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        req_valid,
	input  wire logic [2:0]                  req_cmd,
	input  wire logic                        sr_abort_en,
	input  wire logic                        parity_en,
	input  wire logic [dram_sr_pkg::PL_W-1:0] parity_latency,
	output var  logic                        req_ready,
	output var  logic                        req_ack,
	output var  logic [2:0]                  ddr_cmd,
	output var  logic                        ddr_cke,
	output var  logic                        ddr_clk_en,
	output var  logic                        ddr_reset_n,
	output var  logic [dram_sr_pkg::NUM_CLS-1:0] class_open
);

	localparam int unsigned WW = dram_sr_pkg::WAIT_W;
	localparam int unsigned CW = dram_sr_pkg::CKE_W;

	// exit waits, ns terms rounded up
	localparam int unsigned XPR_CYC = dram_sr_pkg::max2(dram_sr_pkg::XPR_NCK,
		dram_sr_pkg::ns_to_cyc(RFC_NS + dram_sr_pkg::EXIT_ADD_NS));
	localparam int unsigned XS_CYC  =
		dram_sr_pkg::ns_to_cyc(RFC_NS + dram_sr_pkg::EXIT_ADD_NS);
	localparam int unsigned XS4_CYC =
		dram_sr_pkg::ns_to_cyc(RFC4_NS + dram_sr_pkg::EXIT_ADD_NS);

	localparam int unsigned WMAX = (1 << WW) - 1;

	if (XPR_CYC > WMAX || XS_CYC > WMAX || DLL_LOCK_CK > WMAX ||
		dram_sr_pkg::INIT_CAL_NCK > WMAX || DLL_LOCK_CK < 1) begin : g_chk
		$error("dram_sr_ctrl: wait figure does not fit the counter");
	end

	localparam int unsigned PL_MAX = (1 << dram_sr_pkg::PL_W) - 1;

	// abort wait shares the counter with the others
	if (XS4_CYC > WMAX) begin : g_chk_fast
		$error("dram_sr_ctrl: abort wait does not fit the counter");
	end

	// worst parity latency must stay reachable by the saturating cke counter
	if (dram_sr_pkg::CKESR_CYC + PL_MAX > (1 << CW) - 1) begin : g_chk_cke
		$error("dram_sr_ctrl: low width does not fit the clock-enable counter");
	end

	if (dram_sr_pkg::CK_VALID_CYC + PL_MAX > WMAX) begin : g_chk_trail
		$error("dram_sr_ctrl: trailing clock window does not fit the counter");
	end

	localparam logic [WW-1:0] W_CKV   = WW'(dram_sr_pkg::CK_VALID_CYC - 1);
	localparam logic [WW-1:0] W_XPR   = WW'(XPR_CYC - 1);
	localparam logic [WW-1:0] W_INIT  = WW'(dram_sr_pkg::INIT_CAL_NCK - 1);
	localparam logic [WW-1:0] W_FULL  = WW'(dram_sr_pkg::FULL_CAL_NCK - 1);
	localparam logic [WW-1:0] W_SHORT = WW'(dram_sr_pkg::SHORT_CAL_NCK - 1);
	localparam logic [CW-1:0] C_PW    = CW'(dram_sr_pkg::CKE_PW_CYC);
	localparam logic [CW-1:0] C_SR    = CW'(dram_sr_pkg::CKESR_CYC);
	localparam logic [CW-1:0] C_MAX   = '1;

	typedef struct packed {
		dram_sr_pkg::state_t st;
		logic [WW-1:0]       wait_c;
		logic [CW-1:0]       cke_c;
		logic                cke;
		logic                clk_en;
		logic                rst_n;
		dram_sr_pkg::cmd_t   cmd;
		logic                ready;
		logic                ack;
		logic [CW-1:0]       pl_sr;
	} ctl_t;

	localparam ctl_t CTL_RST = '{
		st:     dram_sr_pkg::ST_RESET,
		wait_c: '0,
		cke_c:  '0,
		cke:    1'b0,
		clk_en: 1'b0,
		rst_n:  1'b0,
		cmd:    dram_sr_pkg::CMD_DES,
		ready:  1'b0,
		ack:    1'b0,
		pl_sr:  '0
	};

	ctl_t c_reg;
	ctl_t c_next;

	logic [dram_sr_pkg::NUM_CLS-1:0] cls_done;
	logic [WW-1:0]                   cls_val [dram_sr_pkg::NUM_CLS];
	logic                            cls_load;
	logic                            take;
	logic                            cls_ok;
	logic [WW-1:0]                   pl_w;
	logic [CW-1:0]                   pl_c;
	logic [WW-1:0]                   sre_hold;
	logic [CW-1:0]                   ckesr_need;

	// parity latency stretches the low width and the trailing clock
	assign pl_w       = parity_en ? WW'(parity_latency) : '0;
	assign pl_c       = parity_en ? CW'(parity_latency) : '0;
	assign sre_hold   = WW'(W_CKV + pl_w);
	// latched at entry so a parity change during self-refresh cannot shorten the low width
	assign ckesr_need = CW'(C_SR + c_reg.pl_sr);

	// per-class release after self-refresh exit
	always_comb begin
		cls_val[dram_sr_pkg::CLS_PLAIN] = sr_abort_en ? WW'(XS4_CYC) : WW'(XS_CYC);
		cls_val[dram_sr_pkg::CLS_FAST]  = WW'(XS4_CYC);
		cls_val[dram_sr_pkg::CLS_DLL]   = WW'(DLL_LOCK_CK);
	end

	// one timer per class so each releases on its own
	for (genvar i = 0; i < dram_sr_pkg::NUM_CLS; i++) begin : g_cls
		class_timer #(
			.W(WW)
		) u_tmr (
			.clk_sys  (clk_sys),
			.rst      (rst),
			.load     (cls_load),
			.load_val (cls_val[i]),
			.done     (cls_done[i])
		);
	end

	// whether the offered request's class is released now
	always_comb begin
		cls_ok = 1'b0;
		if (c_reg.st == dram_sr_pkg::ST_SELF_REF) begin
			cls_ok = (req_cmd == dram_sr_pkg::REQ_SR_EXIT);
		end else begin
			case (req_cmd)
				dram_sr_pkg::REQ_ZQ_LONG,
				dram_sr_pkg::REQ_ZQ_SHORT,
				dram_sr_pkg::REQ_MRS_FAST: cls_ok = cls_done[dram_sr_pkg::CLS_FAST];
				dram_sr_pkg::REQ_PLAIN:    cls_ok = cls_done[dram_sr_pkg::CLS_PLAIN];
				dram_sr_pkg::REQ_DLL:      cls_ok = cls_done[dram_sr_pkg::CLS_DLL];
				// high pulse of clock enable must be wide enough before it drops
				dram_sr_pkg::REQ_SR_ENTER: cls_ok = cls_done[dram_sr_pkg::CLS_PLAIN] &&
					(c_reg.cke_c >= C_PW);
				default:                   cls_ok = 1'b0;
			endcase
		end
	end

	// ready is part of take, so one offer is never taken twice
	assign take = c_reg.ready && req_valid && cls_ok;

	always_comb begin
		c_next   = c_reg;
		cls_load = 1'b0;
		// deselect on every cycle that issues nothing
		c_next.cmd = dram_sr_pkg::CMD_DES;
		c_next.ack = 1'b0;
		if (c_reg.cke_c != C_MAX) begin
			c_next.cke_c = CW'(c_reg.cke_c + 1'b1);
		end
		if (c_reg.wait_c != '0) begin
			c_next.wait_c = WW'(c_reg.wait_c - 1'b1);
		end
		case (c_reg.st)
			// reset pin released and clock started together, well before cke
			dram_sr_pkg::ST_RESET: begin
				c_next.st     = dram_sr_pkg::ST_PRE_CLK;
				c_next.rst_n  = 1'b1;
				c_next.clk_en = 1'b1;
				c_next.wait_c = W_CKV;
			end
			// clock stable before cke rises
			dram_sr_pkg::ST_PRE_CLK: begin
				if (c_reg.wait_c == '0) begin
					c_next.cke    = 1'b1;
					c_next.cke_c  = '0;
					c_next.st     = dram_sr_pkg::ST_XPR;
					c_next.wait_c = W_XPR;
				end
			end
			// first command only once the reset-exit wait is over
			dram_sr_pkg::ST_XPR: begin
				if (c_reg.wait_c == '0) begin
					c_next.cmd    = dram_sr_pkg::CMD_ZQ_LONG;
					c_next.st     = dram_sr_pkg::ST_INIT_CAL;
					c_next.wait_c = W_INIT;
				end
			end
			// calibration window, deselect only
			dram_sr_pkg::ST_INIT_CAL,
			dram_sr_pkg::ST_BUSY: begin
				if (c_reg.wait_c == '0) begin
					c_next.st = dram_sr_pkg::ST_IDLE;
				end
			end
			// at most one take every other cycle; the ack cycle keeps ready low
			dram_sr_pkg::ST_IDLE: begin
				if (take) begin
					c_next.ack = 1'b1;
					case (req_cmd)
						dram_sr_pkg::REQ_ZQ_LONG: begin
							c_next.cmd    = dram_sr_pkg::CMD_ZQ_LONG;
							c_next.st     = dram_sr_pkg::ST_BUSY;
							c_next.wait_c = W_FULL;
						end
						dram_sr_pkg::REQ_ZQ_SHORT: begin
							c_next.cmd    = dram_sr_pkg::CMD_ZQ_SHORT;
							c_next.st     = dram_sr_pkg::ST_BUSY;
							c_next.wait_c = W_SHORT;
						end
						dram_sr_pkg::REQ_MRS_FAST: begin
							c_next.cmd = dram_sr_pkg::CMD_MRS;
						end
						dram_sr_pkg::REQ_PLAIN: begin
							c_next.cmd = dram_sr_pkg::CMD_PLAIN;
						end
						dram_sr_pkg::REQ_DLL: begin
							c_next.cmd = dram_sr_pkg::CMD_DLL;
						end
						dram_sr_pkg::REQ_SR_ENTER: begin
							c_next.cmd    = dram_sr_pkg::CMD_SR_ENTER;
							c_next.pl_sr  = pl_c;
							c_next.cke    = 1'b0;
							c_next.cke_c  = '0;
							c_next.st     = dram_sr_pkg::ST_SRE_HOLD;
							c_next.wait_c = sre_hold;
						end
						default: c_next.ack = 1'b0;
					endcase
				end
			end
			dram_sr_pkg::ST_SRE_HOLD: begin
				// clock may stop only after the trailing valid window
				if (c_reg.wait_c == '0) begin
					c_next.clk_en = 1'b0;
					c_next.st     = dram_sr_pkg::ST_SELF_REF;
				end
			end
			// only the exit request is taken here
			dram_sr_pkg::ST_SELF_REF: begin
				if (take) begin
					c_next.ack    = 1'b1;
					c_next.clk_en = 1'b1;
					c_next.st     = dram_sr_pkg::ST_SRX_CLK;
					c_next.wait_c = W_CKV;
				end
			end
			dram_sr_pkg::ST_SRX_CLK: begin
				// exit needs both the leading clock and the minimum low width
				if (c_reg.wait_c == '0 && c_reg.cke_c >= ckesr_need) begin
					c_next.cke   = 1'b1;
					c_next.cke_c = '0;
					c_next.st    = dram_sr_pkg::ST_IDLE;
					cls_load     = 1'b1;
				end
			end
			// unused codes restart the whole bring-up
			default: c_next = CTL_RST;
		endcase
		// ready is registered from the next state, so it always matches the current state
		c_next.ready = (c_next.st == dram_sr_pkg::ST_IDLE && !c_next.ack) ||
			c_next.st == dram_sr_pkg::ST_SELF_REF;
	end

	// async reset loads only the constant image
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			c_reg <= CTL_RST;
		end else begin
			c_reg <= c_next;
		end
	end

	// every output is a register image
	assign req_ready   = c_reg.ready;
	assign req_ack     = c_reg.ack;
	assign ddr_cmd     = c_reg.cmd;
	assign ddr_cke     = c_reg.cke;
	assign ddr_clk_en  = c_reg.clk_en;
	assign ddr_reset_n = c_reg.rst_n;
	assign class_open  = cls_done;

endmodule : dram_sr_ctrl
`default_nettype wire

// ### dram_sr_ctrl_checker.sv
// port assertions for the self-refresh and calibration sequencer
`default_nettype none
module dram_sr_ctrl_checker #(
	parameter int unsigned RFC_NS      = 350,
	parameter int unsigned RFC4_NS     = 160,
	parameter int unsigned DLL_LOCK_CK = 768
) (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       req_ack,
	input wire logic [2:0] ddr_cmd,
	input wire logic       ddr_cke,
	input wire logic       ddr_clk_en,
	input wire logic       sr_abort_en,
	input wire logic       parity_en,
	input wire logic [2:0] parity_latency
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PER = dram_sr_pkg::CLK_PERIOD_PS;
	localparam int XS  = ((RFC_NS + 10) * 1000 + PER - 1) / PER;
	localparam int XSA = ((RFC4_NS + 10) * 1000 + PER - 1) / PER;
	localparam int XPR = (XS > 5) ? XS : 5;
	logic [10:0] gap, hi, lo, on;
	logic [2:0]  last;
	logic [1:0]  ncmd;
	logic        srx;
	int          pl;
	wire logic   cmd_on = (ddr_cmd != dram_sr_pkg::CMD_DES);
	assign pl = parity_en ? int'(parity_latency) : 0;

	// saturating so long idle stretches never wrap into a short gap
	function automatic logic [10:0] inc(input logic [10:0] v);
		return (v == 11'h7ff) ? v : v + 11'h1;
	endfunction : inc

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{gap, hi, lo, on, last, ncmd, srx} <= '0;
		end else begin
			gap <= cmd_on ? 11'h001 : inc(gap);
			hi <= ddr_cke ? inc(hi) : 11'h000;
			lo <= ddr_cke ? 11'h000 : inc(lo);
			on <= ddr_clk_en ? inc(on) : 11'h000;
			if (cmd_on) begin
				last <= ddr_cmd;
				ncmd <= (ncmd == 2'h3) ? ncmd : ncmd + 2'h1;
			end
			if (ddr_cmd == dram_sr_pkg::CMD_SR_ENTER) begin
				srx <= 1'b1;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// the very first command is the controller's own init calibration, unrequested
	cmd_ack_a: assert property (cmd_on && ncmd != 2'h0 |-> req_ack)
		else $error("command without acknowledge");
	init_cal_a: assert property (cmd_on && ncmd == 2'h1 |-> gap >= 11'd1024)
		else $error("command inside init calibration");
	full_cal_a: assert property (cmd_on && ncmd > 2'h1 && last == dram_sr_pkg::CMD_ZQ_LONG
		|-> gap >= 11'd512) else $error("command inside full calibration");
	short_cal_a: assert property (cmd_on && last == dram_sr_pkg::CMD_ZQ_SHORT
		|-> gap >= 11'd128) else $error("command inside short calibration");
	reset_exit_a: assert property (cmd_on && ncmd == 2'h0 |-> hi >= XPR)
		else $error("first command too early after clock enable");
	plain_wait_a: assert property (ddr_cmd == dram_sr_pkg::CMD_PLAIN && srx
		|-> hi >= (sr_abort_en ? XSA : XS)) else $error("plain command too early");
	fast_wait_a: assert property ((ddr_cmd inside {3'h1, 3'h2, 3'h3}) && srx
		|-> hi >= XSA) else $error("calibration or mode write too early");
	dll_wait_a: assert property (ddr_cmd == dram_sr_pkg::CMD_DLL && srx
		|-> hi >= DLL_LOCK_CK) else $error("dll command before lock");
	cke_low_a: assert property ($rose(ddr_cke) && ncmd != 2'h0
		|-> lo >= dram_sr_pkg::CKESR_CYC + pl) else $error("self-refresh low too short");
	cke_pulse_a: assert property ($fell(ddr_cke) |-> hi >= dram_sr_pkg::CKE_PW_CYC)
		else $error("clock enable high pulse too short");
	clk_after_a: assert property ($fell(ddr_clk_en)
		|-> gap >= dram_sr_pkg::CK_VALID_CYC + pl) else $error("clock stopped too soon");
	clk_before_a: assert property ($rose(ddr_cke) |-> on >= dram_sr_pkg::CK_VALID_CYC)
		else $error("clock not stable before exit");
endmodule : dram_sr_ctrl_checker

bind dram_sr_ctrl dram_sr_ctrl_checker #(.RFC_NS(RFC_NS), .RFC4_NS(RFC4_NS),
	.DLL_LOCK_CK(DLL_LOCK_CK)) chk (.clk_sys, .rst, .req_ack, .ddr_cmd, .ddr_cke,
	.ddr_clk_en, .sr_abort_en, .parity_en, .parity_latency);
`default_nettype wire

// ### dram_dev_model.sv
// behavioural dram that counts commands landing inside calibration windows
`default_nettype none
module dram_dev_model (
	input  wire logic       clk_sys,
	input  wire logic       ddr_reset_n,
	input  wire logic       ddr_clk_en,
	input  wire logic [2:0] ddr_cmd,
	output var  int         viol
);
	timeunit 1ns;
	timeprecision 1ns;
	int   busy;
	logic cal_seen;
	always @(posedge clk_sys or negedge ddr_reset_n) begin
		if (!ddr_reset_n) begin
			viol <= 0;
			busy <= 0;
			cal_seen <= 1'b0;
		end else if (ddr_clk_en) begin
			// a stopped clock means the device samples nothing
			if (busy > 0) begin
				busy <= busy - 1;
			end
			if (ddr_cmd != 3'h0) begin
				if (busy > 0) begin
					viol <= viol + 1;
				end
				if (ddr_cmd == 3'h1) begin
					busy <= cal_seen ? 511 : 1023;
					cal_seen <= 1'b1;
				end
				if (ddr_cmd == 3'h2) begin
					busy <= 127;
				end
			end
		end
	end
endmodule : dram_dev_model
`default_nettype wire

// ### dram_sr_ctrl_tb_top.sv
// testbench for the self-refresh and calibration sequencer
`default_nettype none
module dram_sr_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       req_valid = 1'b0;
	logic [2:0] req_cmd = 3'h0;
	logic       sr_abort_en = 1'b0;
	logic       parity_en = 1'b0;
	logic [2:0] parity_latency = 3'h0;
	logic       req_ready, req_ack, ddr_cke, ddr_clk_en, ddr_reset_n;
	logic [2:0] ddr_cmd, class_open;
	logic       cke_q = 1'b0, clk_q = 1'b0;
	int         viol, cyc = 0, err_count = 0, tests_run = 0;
	int         t_ckr, t_ckf, t_clf, t_clr, t_first = -1;

	always #50 clk_sys = ~clk_sys;

	dram_sr_ctrl #(.RFC_NS(350), .RFC4_NS(160), .DLL_LOCK_CK(768)) uut (
		.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
		.sr_abort_en(sr_abort_en), .parity_en(parity_en), .parity_latency(parity_latency),
		.req_ready(req_ready), .req_ack(req_ack), .ddr_cmd(ddr_cmd), .ddr_cke(ddr_cke),
		.ddr_clk_en(ddr_clk_en), .ddr_reset_n(ddr_reset_n), .class_open(class_open));
	dram_dev_model dev (.clk_sys(clk_sys), .ddr_reset_n(ddr_reset_n),
		.ddr_clk_en(ddr_clk_en), .ddr_cmd(ddr_cmd), .viol(viol));

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input int lo, input int hi, input int seen);
		tests_run++;
		if (seen < lo || seen > hi) begin
			err_count++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask : check

	task automatic checkv(input string what, input logic [7:0] exp, input logic [7:0] seen);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : checkv

	// edges recorded from pre-edge values so every delta uses one convention
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		cke_q <= ddr_cke;
		clk_q <= ddr_clk_en;
		if (ddr_cke && !cke_q) t_ckr <= cyc;
		if (!ddr_cke && cke_q) t_ckf <= cyc;
		if (ddr_clk_en && !clk_q) t_clr <= cyc;
		if (!ddr_clk_en && clk_q) t_clf <= cyc;
		if (t_first < 0 && ddr_cmd != 3'h0) t_first <= cyc;
		if (cyc == 12000) begin
			err_count++;
			give_verdict();
		end
	end

	// request held until acknowledged or for at most 1500 cycles; refusals simply stretch the wait
	task automatic issue(input logic [2:0] rq, input logic [2:0] exp_cmd, output int t);
		int n;
		n = 0;
		@(posedge clk_sys);
		req_cmd <= rq;
		req_valid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ack !== 1'b1 && n < 1500);
		req_valid <= 1'b0;
		t = cyc;
		checkv("acknowledge", 8'h01, {7'h0, req_ack});
		checkv("command", {5'h0, exp_cmd}, {5'h0, ddr_cmd});
	endtask : issue

	task automatic s_reset;
		int n;
		repeat (16) @(posedge clk_sys);
		checkv("reset outputs", 8'h00,
			{ddr_reset_n, ddr_cke, ddr_clk_en, req_ready, req_ack, ddr_cmd});
		checkv("reset classes", 8'h07, {5'h0, class_open});
		rst <= 1'b0;
		for (n = 0; n < 1200 && req_ready !== 1'b1; n++) @(posedge clk_sys);
		checkv("reset pin released", 8'h01, {7'h0, ddr_reset_n});
		check("init calibration", 1024, 1027, cyc - t_first);
		check("first command", 5, 7, t_first - t_ckr);
		check("clock before cke", 5, 7, t_ckr - t_clr);
	endtask : s_reset

	task automatic s_zq;
		int t0, t1;
		issue(dram_sr_pkg::REQ_ZQ_LONG, dram_sr_pkg::CMD_ZQ_LONG, t0);
		issue(dram_sr_pkg::REQ_MRS_FAST, dram_sr_pkg::CMD_MRS, t1);
		check("full calibration gap", 512, 516, t1 - t0);
		issue(dram_sr_pkg::REQ_ZQ_SHORT, dram_sr_pkg::CMD_ZQ_SHORT, t0);
		issue(dram_sr_pkg::REQ_PLAIN, dram_sr_pkg::CMD_PLAIN, t1);
		check("short calibration gap", 128, 132, t1 - t0);
	endtask : s_zq

	task automatic s_sr(input logic ab, input logic par);
		int t0, t1, t2, t3, pl;
		pl = par ? 3 : 0;
		@(posedge clk_sys);
		sr_abort_en <= ab;
		parity_en <= par;
		parity_latency <= 3'h3;
		issue(dram_sr_pkg::REQ_SR_ENTER, dram_sr_pkg::CMD_SR_ENTER, t0);
		issue(dram_sr_pkg::REQ_SR_EXIT, dram_sr_pkg::CMD_DES, t1);
		issue(dram_sr_pkg::REQ_PLAIN, dram_sr_pkg::CMD_PLAIN, t2);
		checkv("classes after exit", 8'h03, {5'h0, class_open});
		issue(dram_sr_pkg::REQ_MRS_FAST, dram_sr_pkg::CMD_MRS, t3);
		check("cke low width", 4 + pl, 30 + pl, t_ckr - t_ckf);
		check("clock after entry", 5 + pl, 7 + pl, t_clf - t_ckf);
		check("clock before exit", 5, 7, t_ckr - t_clr);
		check("plain class", ab ? 2 : 4, ab ? 4 : 6, t2 - t_ckr);
		check("fast class", 2, 10, t3 - t_ckr);
		issue(dram_sr_pkg::REQ_DLL, dram_sr_pkg::CMD_DLL, t3);
		check("dll class", 768, 772, t3 - t_ckr);
	endtask : s_sr

	initial begin
		s_reset();
		s_zq();
		for (int i = 0; i < 4; i++) s_sr(i[0], i[1]);
		check("device violations", 0, 0, viol);
		give_verdict();
	end
endmodule : dram_sr_ctrl_tb_top
`default_nettype wire
